// ---- testbench/mac_config_chk.sv ----
// assertion checker for the alarm and pin configuration bank
`timescale 1ns/1ps
`default_nettype none

module mac_config_chk
    import mac_pkg::*;
(
    input wire logic        clock_in,                 // clock
    input wire logic        resetn_in,                // reset, active low
    input wire logic [6:0]  reg_addr_in,              // address
    input wire logic [15:0] reg_wdata_in,             // write data
    input wire logic        reg_write_in,             // write strobe
    input wire logic        reg_read_in,              // read strobe
    input wire logic [15:0] reg_rdata_out,            // read data
    input wire logic        reg_rvalid_out,           // read valid
    input wire logic        data_available_signal,    // source one
    input wire logic        conversion_ready_in,      // source two
    input wire logic        ready_pin_out,            // pin level
    input wire logic        ready_pin_oe_out,         // pin enable
    input wire logic        remote_diode_pnp_select,  // diode mode
    input wire logic        amp_on_request_in,        // amp request
    input wire logic        negative_supply_alarm_in, // supply alarm
    input wire logic        amplifier_on_output,      // amp pin
    input wire logic [14:0] channel_enable_out,       // channel enables
    input wire logic [14:0] sample_valid_in,          // sample pulses
    input wire logic [14:0] out_of_range_in,          // limit breach
    input wire logic [14:0] alarm_out                 // alarms
);
    // ------------------------------------------------------------
    // shadow registers rebuilt from port traffic
    // ------------------------------------------------------------
    logic [15:0] cfg_q;
    logic [15:0] sel_q;
    logic        trip_q;
    logic [15:0] rd_exp;

    // trip clears only once the alarm and the request are both gone
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            cfg_q  <= ALARM_CFG_RESET;
            sel_q  <= CHAN_SEL_RESET;
            trip_q <= 1'b0;
        end else begin
            if (reg_write_in && reg_addr_in == ALARM_CFG_ADDR) cfg_q <= reg_wdata_in;
            if (reg_write_in && reg_addr_in == CHAN_SEL_ADDR) sel_q <= reg_wdata_in;
            trip_q <= (trip_q || (cfg_q[6] && negative_supply_alarm_in))
                      && (negative_supply_alarm_in || amp_on_request_in);
        end
    end

    assign rd_exp = (reg_addr_in == ALARM_CFG_ADDR) ? cfg_q :
                    (reg_addr_in == CHAN_SEL_ADDR) ? sel_q : READ_UNMAPPED;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_read_answer: assert property (reg_read_in |=> reg_rvalid_out && reg_rdata_out == $past(rd_exp))
        else $error("read answer wrong");
    a_valid_cause: assert property (reg_rvalid_out |-> $past(reg_read_in))
        else $error("read valid without read");
    a_oe_tracks_en: assert property ($past(resetn_in) |-> ready_pin_oe_out == $past(cfg_q[15]))
        else $error("pin enable wrong");
    a_pin_quiet_off: assert property ($past(resetn_in) && !$past(cfg_q[15]) |-> !ready_pin_out)
        else $error("pin driven while off");
    a_pin_source: assert property ($past(resetn_in) && $past(cfg_q[15]) |-> ready_pin_out ==
        $past(cfg_q[14] ? conversion_ready_in : data_available_signal))
        else $error("pin source wrong");
    a_pnp_mode: assert property (remote_diode_pnp_select == cfg_q[PNP_BIT])
        else $error("diode mode wrong");
    a_chan_enable: assert property (channel_enable_out == sel_q[14:0])
        else $error("channel enables wrong");
    a_amp_trip: assert property ($past(resetn_in) |-> amplifier_on_output == $past(amp_on_request_in
        && !trip_q && !(cfg_q[6] && negative_supply_alarm_in)))
        else $error("amplifier level wrong");
    a_alarm_ignored: assert property (!cfg_q[6] && !trip_q && amp_on_request_in |=> amplifier_on_output)
        else $error("amplifier dropped");
    a_inrange_clears: assert property (sample_valid_in[LT_CHAN] && channel_enable_out[LT_CHAN]
        && !out_of_range_in[LT_CHAN] |=> !alarm_out[LT_CHAN])
        else $error("alarm kept after good sample");
    a_unsel_quiet: assert property (!channel_enable_out[0] && !alarm_out[0] |=> !alarm_out[0])
        else $error("skipped channel alarmed");

    c_cfg_read: cover property (reg_read_in && reg_addr_in == ALARM_CFG_ADDR);
    c_amp_off: cover property ($fell(amplifier_on_output));
    c_alarm_up: cover property ($rose(alarm_out[LT_CHAN]));
endmodule : mac_config_chk

bind mac_config mac_config_chk mac_config_chk_i (.*);

`default_nettype wire

// ---- testbench/mac_config_tb_top.sv ----
// self-checking testbench for the alarm and pin configuration bank
`timescale 1ns/1ps
`default_nettype none

module mac_config_tb_top;
    import mac_pkg::*;
    logic        clock_in, resetn_in, write, read, rvalid, avail, conv, pin, oe, pnp;
    logic        req, neg, amp;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic [14:0] en, valid, oor, alarm;
    int          num_errors = 0;
    int          total_checks = 0;

    mac_config mac_config_i (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(write), .reg_read_in(read), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .data_available_signal(avail), .conversion_ready_in(conv),
        .ready_pin_out(pin), .ready_pin_oe_out(oe), .remote_diode_pnp_select(pnp),
        .amp_on_request_in(req), .negative_supply_alarm_in(neg), .amplifier_on_output(amp),
        .channel_enable_out(en), .sample_valid_in(valid), .out_of_range_in(oor),
        .alarm_out(alarm));
    mac_host mac_host_i (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wdata_out(wdata), .write_out(write), .read_out(read));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : wait_cyc

    // one sample on a channel, with a quiet cycle after it
    task automatic pulse(input int ch, input logic o);
        @(posedge clock_in);
        valid[ch] <= 1'b1;
        oor[ch]   <= o;
        @(posedge clock_in);
        valid[ch] <= 1'b0;
    endtask : pulse

    // short run, broken run, full run, then a good sample
    task automatic run_filter(input int ch, input int n);
        repeat (n - 1) pulse(ch, 1'b1);
        wait_cyc(2);
        chk("alarm short run", alarm[ch], 1'b0);
        pulse(ch, 1'b0);
        repeat (n - 1) pulse(ch, 1'b1);
        wait_cyc(2);
        chk("alarm broken run", alarm[ch], 1'b0);
        pulse(ch, 1'b1);
        wait_cyc(2);
        chk("alarm full run", alarm[ch], 1'b1);
        pulse(ch, 1'b0);
        wait_cyc(2);
        chk("alarm cleared", alarm[ch], 1'b0);
    endtask : run_filter

    task automatic t_reset();
        mac_host_i.rd(ALARM_CFG_ADDR, v);
        chk("cfg reset", v, 16'h036a);
        mac_host_i.rd(CHAN_SEL_ADDR, v);
        chk("select reset", v, 16'h0000);
        mac_host_i.rd(7'h13, v);
        chk("unmapped read", v, READ_UNMAPPED);
        chk("oe reset", oe, 1'b0);
        chk("pnp reset", pnp, 1'b0);
        chk("pin reset", pin, 1'b0);
        chk("enables reset", {1'b0, en}, 16'h0000);
        chk("amp reset", amp, 1'b0);
        chk("alarms reset", {1'b0, alarm}, 16'h0000);
    endtask : t_reset

    task automatic t_ready_pin();
        @(posedge clock_in);
        avail <= 1'b1;
        mac_host_i.wr(ALARM_CFG_ADDR, 16'h836a);
        wait_cyc(3);
        chk("pin avail", pin, 1'b1);
        chk("oe on", oe, 1'b1);
        @(posedge clock_in);
        avail <= 1'b0;
        conv  <= 1'b1;
        wait_cyc(3);
        chk("pin avail low", pin, 1'b0);
        mac_host_i.wr(ALARM_CFG_ADDR, 16'hc36a);
        wait_cyc(3);
        chk("pin conv", pin, 1'b1);
        mac_host_i.wr(ALARM_CFG_ADDR, 16'h436a);
        wait_cyc(3);
        chk("oe off", oe, 1'b0);
        chk("pin off", pin, 1'b0);
    endtask : t_ready_pin

    task automatic t_regs();
        mac_host_i.wr(CHAN_SEL_ADDR, 16'h7fff);
        mac_host_i.wr(ALARM_CFG_ADDR, 16'hf8ea);
        wait_cyc(1);
        chk("enables", {1'b0, en}, 16'h7fff);
        chk("pnp on", pnp, 1'b1);
        mac_host_i.rd(ALARM_CFG_ADDR, v);
        chk("cfg readback", v, 16'hc0ea);
        mac_host_i.rd(CHAN_SEL_ADDR, v);
        chk("select readback", v, 16'h7fff);
        mac_host_i.wr(ALARM_CFG_ADDR, 16'h036a);
    endtask : t_regs

    task automatic t_amp();
        @(posedge clock_in) req <= 1'b1;
        wait_cyc(2);
        chk("amp on", amp, 1'b1);
        @(posedge clock_in) neg <= 1'b1;
        wait_cyc(2);
        chk("amp tripped", amp, 1'b0);
        @(posedge clock_in) neg <= 1'b0;
        wait_cyc(2);
        chk("amp held off", amp, 1'b0);
        @(posedge clock_in) req <= 1'b0;
        @(posedge clock_in) req <= 1'b1;
        wait_cyc(2);
        chk("amp rearmed", amp, 1'b1);
        mac_host_i.wr(ALARM_CFG_ADDR, 16'h032a);
        @(posedge clock_in) neg <= 1'b1;
        wait_cyc(3);
        chk("amp ignores alarm", amp, 1'b1);
        @(posedge clock_in) neg <= 1'b0;
    endtask : t_amp

    // every temperature code on each sensor, every channel code on one input
    task automatic t_filters();
        for (int t = 0; t < 4; t++) begin
            mac_host_i.wr(ALARM_CFG_ADDR, 16'h0300 | 16'(t * 21));
            for (int ch = 12; ch < 15; ch++) run_filter(ch, 1 << t);
        end
        for (int c = 0; c < 8; c++) begin
            mac_host_i.wr(ALARM_CFG_ADDR, 16'h002a | 16'(c << 8));
            run_filter(0, (c == 0) ? 1 : (2 << c));
        end
        mac_host_i.wr(ALARM_CFG_ADDR, 16'h002a);
        mac_host_i.wr(CHAN_SEL_ADDR, 16'h7ffe);
        repeat (2) pulse(0, 1'b1);
        wait_cyc(2);
        chk("skipped channel", alarm[0], 1'b0);
    endtask : t_filters

    initial begin
        #1_000_000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        {resetn_in, avail, conv, req, neg} = '0;
        valid = '0;
        oor   = '0;
        repeat (16) @(posedge clock_in);
        resetn_in <= 1'b1;
        t_reset();
        t_ready_pin();
        t_regs();
        t_amp();
        t_filters();
        tally_and_finish();
    end
endmodule : mac_config_tb_top

`default_nettype wire

// ---- testbench/mac_host.sv ----
// host model issuing register writes and reads to the bank
`timescale 1ns/1ps
`default_nettype none

module mac_host
    import mac_pkg::*;
(
    input  wire logic                       clock_in,  // system clock
    input  wire logic [mac_pkg::DATA_W-1:0] rdata_in,  // read data
    input  wire logic                       rvalid_in, // read valid
    output logic      [mac_pkg::ADDR_W-1:0] addr_out,  // address
    output logic      [mac_pkg::DATA_W-1:0] wdata_out, // write data
    output logic                            write_out, // write strobe
    output logic                            read_out   // read strobe
);
    initial begin
        addr_out  = '0;
        wdata_out = '0;
        write_out = 1'b0;
        read_out  = 1'b0;
    end

    // software never sets the factory bits 13..11
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_out  <= a;
        wdata_out <= (a == ALARM_CFG_ADDR) ? (d & 16'hc7ff) : d;
        write_out <= 1'b1;
        @(posedge clock_in);
        write_out <= 1'b0;
    endtask : wr

    // a read that never answers returns unknowns so the compare fails
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        d = 'x;
        @(posedge clock_in);
        addr_out <= a;
        read_out <= 1'b1;
        @(posedge clock_in);
        read_out <= 1'b0;
        #1;
        for (int i = 0; i < 4; i++) begin
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                break;
            end
            @(posedge clock_in);
            #1;
        end
    endtask : rd
endmodule : mac_host

`default_nettype wire

// ---- verilog/mac_alarm_filter.sv ----
// consecutive out-of-range sample filter for one alarm channel
`timescale 1ns/1ps
`default_nettype none

module mac_alarm_filter #(
    parameter int CNT_W = 9
) (
    input  wire logic             clock_in,        // system clock
    input  wire logic             resetn_in,       // synchronous reset, active low
    input  wire logic             sample_valid_in, // one-cycle pulse per conversion
    input  wire logic             out_of_range_in, // sample outside limits
    input  wire logic [CNT_W-1:0] runs_in,         // samples needed to raise alarm
    output logic                  alarm_out        // filtered alarm level
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (CNT_W < 2) begin : g_bad_width
        $error("mac_alarm_filter: CNT_W must be at least 2");
    end

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             alarm_q;
    logic             alarm_d;

    // count an unbroken run; the counter saturates at the threshold so
    // a long alarm never wraps back to a quiet state
    always_comb begin
        count_d = count_q;
        alarm_d = alarm_q;
        if (sample_valid_in) begin
            if (!out_of_range_in) begin
                count_d = '0;
                alarm_d = 1'b0;
            end else if (count_q + 1'b1 >= runs_in) begin
                count_d = runs_in;
                alarm_d = 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    // register the filter state
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            count_q <= '0;
            alarm_q <= 1'b0;
        end else begin
            count_q <= count_d;
            alarm_q <= alarm_d;
        end
    end

    assign alarm_out = alarm_q;

endmodule : mac_alarm_filter

`default_nettype wire

// ---- verilog/mac_config.sv ----
// alarm and pin configuration bank with channel select and alarm filters
`timescale 1ns/1ps
`default_nettype none

module mac_config
    import mac_pkg::*;
(
    input  wire logic                        clock_in,            // system clock, 100 MHz
    input  wire logic                        resetn_in,           // synchronous reset, active low
    // register port from the serial host interface
    input  wire logic [mac_pkg::ADDR_W-1:0]  reg_addr_in,         // register address
    input  wire logic [mac_pkg::DATA_W-1:0]  reg_wdata_in,        // write data
    input  wire logic                        reg_write_in,        // write strobe, one cycle
    input  wire logic                        reg_read_in,         // read strobe, one cycle
    output logic      [mac_pkg::DATA_W-1:0]  reg_rdata_out,       // read data, next cycle
    output logic                             reg_rvalid_out,      // read data valid pulse
    // shared ready pin
    input  wire logic                        data_available_signal, // data-available source
    input  wire logic                        conversion_ready_in, // conversion-ready source
    output logic                             ready_pin_out,       // ready pin level
    output logic                             ready_pin_oe_out,    // ready pin driven when high
    // remote diode mode
    output logic                             remote_diode_pnp_select, // both remote diodes PNP
    // amplifier control
    input  wire logic                        amp_on_request_in,   // software wants amplifier on
    input  wire logic                        negative_supply_alarm_in, // supply alarm level
    output logic                             amplifier_on_output, // amplifier-on pin
    // conversion sequencing and alarm filtering
    output logic      [mac_pkg::NUM_CHAN-1:0] channel_enable_out, // channels in the cycle
    input  wire logic [mac_pkg::NUM_CHAN-1:0] sample_valid_in,    // per-channel sample pulse
    input  wire logic [mac_pkg::NUM_CHAN-1:0] out_of_range_in,    // per-channel limit breach
    output logic      [mac_pkg::NUM_CHAN-1:0] alarm_out           // filtered alarms
);

    import mac_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [DATA_W-1:0] alarm_cfg_q;
    logic [DATA_W-1:0] alarm_cfg_d;
    logic [DATA_W-1:0] chan_sel_q;
    logic [DATA_W-1:0] chan_sel_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              rvalid_q;
    logic              rvalid_d;

    // writes land whole; the reserved bits 13..11 and bit 15 of the
    // select register are stored as written so readback matches
    always_comb begin
        alarm_cfg_d = alarm_cfg_q;
        chan_sel_d  = chan_sel_q;
        if (reg_write_in) begin
            if (reg_addr_in == ALARM_CFG_ADDR) begin
                alarm_cfg_d = reg_wdata_in;
            end
            if (reg_addr_in == CHAN_SEL_ADDR) begin
                chan_sel_d = reg_wdata_in;
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        rvalid_d = reg_read_in;
        rdata_d  = rdata_q;
        if (reg_read_in) begin
            if (reg_addr_in == ALARM_CFG_ADDR) begin
                rdata_d = alarm_cfg_q;
            end else if (reg_addr_in == CHAN_SEL_ADDR) begin
                rdata_d = chan_sel_q;
            end else begin
                rdata_d = READ_UNMAPPED;
            end
        end
    end

    // register the bank and the read answer
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            alarm_cfg_q <= ALARM_CFG_RESET;
            chan_sel_q  <= CHAN_SEL_RESET;
            rdata_q     <= READ_UNMAPPED;
            rvalid_q    <= 1'b0;
        end else begin
            alarm_cfg_q <= alarm_cfg_d;
            chan_sel_q  <= chan_sel_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
        end
    end

    // read data holds until the next read, so a slow host can still
    // pick it up after the valid pulse has gone
    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic       ready_pin_enable;
    logic       ready_pin_function_select;
    logic       supply_alarm_amp_shutoff;
    logic [2:0] channel_alarm_filter;
    logic [1:0] local_temp_alarm_filter;
    logic [1:0] remote_two_alarm_filter;
    logic [1:0] remote_one_alarm_filter;

    assign ready_pin_enable          = alarm_cfg_q[READY_EN_BIT];
    assign ready_pin_function_select = alarm_cfg_q[READY_SEL_BIT];
    assign supply_alarm_amp_shutoff  = alarm_cfg_q[SHUTOFF_BIT];
    assign channel_alarm_filter      = alarm_cfg_q[CH_FILT_LSB +: 3];
    assign local_temp_alarm_filter   = alarm_cfg_q[LT_FILT_LSB +: 2];
    assign remote_two_alarm_filter   = alarm_cfg_q[RT2_FILT_LSB +: 2];
    assign remote_one_alarm_filter   = alarm_cfg_q[RT1_FILT_LSB +: 2];

    // ------------------------------------------------------------
    // shared ready pin
    // ------------------------------------------------------------
    logic ready_pin_q;
    logic ready_pin_d;
    logic ready_oe_q;
    logic ready_oe_d;

    // the pin level is registered so a select change never glitches it
    always_comb begin
        ready_oe_d  = ready_pin_enable;
        ready_pin_d = 1'b0;
        if (ready_pin_enable) begin
            ready_pin_d = ready_pin_function_select ? conversion_ready_in
                                                    : data_available_signal;
        end
    end

    // register the pin
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            ready_pin_q <= 1'b0;
            ready_oe_q  <= 1'b0;
        end else begin
            ready_pin_q <= ready_pin_d;
            ready_oe_q  <= ready_oe_d;
        end
    end

    assign ready_pin_out    = ready_pin_q;
    assign ready_pin_oe_out = ready_oe_q;

    // remote diode transistor type goes straight from its bit
    assign remote_diode_pnp_select = alarm_cfg_q[PNP_BIT];

    // ------------------------------------------------------------
    // amplifier interlock
    // ------------------------------------------------------------
    logic tripped_q;
    logic tripped_d;
    logic amp_on_q;
    logic amp_on_d;

    // once tripped the amplifier stays off until the supply alarm has
    // gone and software has dropped its on request, so a bouncing
    // alarm cannot toggle the amplifier on its own
    always_comb begin
        tripped_d = tripped_q;
        if (supply_alarm_amp_shutoff && negative_supply_alarm_in) begin
            tripped_d = 1'b1;
        end else if (!negative_supply_alarm_in && !amp_on_request_in) begin
            tripped_d = 1'b0;
        end
        // with shutoff clear the alarm cannot trip the pin; it only holds off the clearing of a trip already latched
        amp_on_d = amp_on_request_in && !tripped_d;
    end

    // register the interlock
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            tripped_q <= 1'b0;
            amp_on_q  <= 1'b0;
        end else begin
            tripped_q <= tripped_d;
            amp_on_q  <= amp_on_d;
        end
    end

    // the interlock can only hold the pin off; turning it on is always
    // the request's doing
    assign amplifier_on_output = amp_on_q;

    // ------------------------------------------------------------
    // channel sequencing and alarm filters
    // ------------------------------------------------------------
    // the sequencer walks only enabled channels; bit 15 of the select
    // register is kept for readback but drives nothing
    assign channel_enable_out = chan_sel_q[NUM_CHAN-1:0];

    // one filter per channel; its threshold comes from the field that
    // covers its sensor group
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_filter
        mac_count_t runs;
        if (ch == LT_CHAN) begin : g_lt
            assign runs = mac_temp_runs(local_temp_alarm_filter);
        end else if (ch == RT2_CHAN) begin : g_rt2
            assign runs = mac_temp_runs(remote_two_alarm_filter);
        end else if (ch == RT1_CHAN) begin : g_rt1
            assign runs = mac_temp_runs(remote_one_alarm_filter);
        end else begin : g_adc
            assign runs = mac_chan_runs(channel_alarm_filter);
        end

        mac_alarm_filter #(
            .CNT_W           (FILT_CNT_W)
        ) u_filter (
            .clock_in        (clock_in),
            .resetn_in       (resetn_in),
            // skipped channels never feed their filter
            .sample_valid_in (sample_valid_in[ch] && chan_sel_q[ch]),
            .out_of_range_in (out_of_range_in[ch]),
            .runs_in         (runs),
            .alarm_out       (alarm_out[ch])
        );
    end

endmodule : mac_config

`default_nettype wire

// ---- verilog/mac_pkg.sv ----
// constants and field layout of the monitor alarm and pin configuration bank
`default_nettype none

package mac_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W            = 7;
    localparam int          DATA_W            = 16;
    localparam logic [6:0]  ALARM_CFG_ADDR    = 7'h11;
    localparam logic [6:0]  CHAN_SEL_ADDR     = 7'h12;
    localparam logic [15:0] ALARM_CFG_RESET   = 16'h036a;
    localparam logic [15:0] CHAN_SEL_RESET    = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED     = 16'h0000;

    // ------------------------------------------------------------
    // alarm and pin configuration fields
    // ------------------------------------------------------------
    localparam int READY_EN_BIT       = 15;
    localparam int READY_SEL_BIT      = 14;
    localparam int CH_FILT_LSB        = 8;
    localparam int PNP_BIT            = 7;
    localparam int SHUTOFF_BIT        = 6;
    localparam int LT_FILT_LSB        = 4;
    localparam int RT2_FILT_LSB       = 2;
    localparam int RT1_FILT_LSB       = 0;

    // ------------------------------------------------------------
    // channel select bits, also the index of each alarm channel
    // ------------------------------------------------------------
    localparam int NUM_CHAN           = 15;
    localparam int LT_CHAN            = 14;
    localparam int RT2_CHAN           = 13;
    localparam int RT1_CHAN           = 12;
    localparam int ADC_CHAN_TOP       = 11;

    // filter counters must hold the largest run of 256 samples
    localparam int FILT_CNT_W         = 9;

    typedef logic [FILT_CNT_W-1:0] mac_count_t;

    // three-bit channel code: 1, 4, 8, 16, 32, 64, 128, 256
    function automatic mac_count_t mac_chan_runs(input logic [2:0] code);
        mac_count_t one;
        one = mac_count_t'(1);
        if (code == 3'h0) begin
            return one;
        end
        // widen before adding so code 111 gives 256 rather than wrapping to 1
        return one << ({1'b0, code} + 4'h1);
    endfunction : mac_chan_runs

    // two-bit temperature code: 1, 2, 4, 8
    function automatic mac_count_t mac_temp_runs(input logic [1:0] code);
        return mac_count_t'(1) << code;
    endfunction : mac_temp_runs

endpackage : mac_pkg

`default_nettype wire
